// file: faw_pkg.sv
// constants and state types for the fault and alarm status word bank
package faw_pkg;
  localparam int WORD_W = 16;
  localparam int AHB_W = 32;
  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] OFS_FAULT_ONE = 8'h00;
  localparam logic [7:0] OFS_FAULT_TWO = 8'h04;
  localparam logic [7:0] OFS_FAULT_THREE = 8'h08;
  localparam logic [7:0] OFS_ALARM_ONE = 8'h0C;
  localparam logic [7:0] OFS_ALARM_TWO = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFS_PANEL_SEL = 8'h1C;
  localparam logic [7:0] OFS_PANEL_HEX = 8'h20;
  // --------------------------------------------------------------
  // bit positions in the first and second fault words
  // --------------------------------------------------------------
  localparam int B1_OVERCURRENT = 0;
  localparam int B1_BUS_HIGH = 1;
  localparam int B1_HEAT = 2;
  localparam int B1_SHORT = 3;
  localparam int B1_OVERLOAD = 4;
  localparam int B1_BUS_LOW = 5;
  localparam int B1_PANEL_LOSS = 9;
  localparam int B1_STALL = 11;
  localparam int B1_EXT_ONE = 13;
  localparam int B1_EXT_TWO = 14;
  localparam int B1_GROUND = 15;
  localparam int B2_UNDERLOAD = 0;
  localparam int B2_THERMISTOR = 1;
  localparam int B2_OPT_LINK = 2;
  localparam int B2_OPT_POWER = 3;
  localparam int B2_CURR_SENSE = 4;
  localparam int B2_SUPPLY_PHASE = 5;
  localparam int B2_SERIAL_LINK = 11;
  localparam int B2_FORCED = 13;
  localparam int B2_MOTOR_PHASE = 14;
  localparam int B2_CABLING = 15;
  // --------------------------------------------------------------
  // interrupt bits, reset values, display codes
  // --------------------------------------------------------------
  localparam int IRQ_FAULT_ONE = 0;
  localparam int IRQ_FAULT_TWO = 1;
  localparam int IRQ_FAULT_THREE = 2;
  localparam int IRQ_ALARM_ONE = 3;
  localparam int IRQ_ALARM_TWO = 4;
  localparam int IRQ_W = 5;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [4:0] IRQ_RST = 5'h00;
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_ALPHA = 8'h37;
  localparam logic [3:0] NIBBLE_TEN = 4'hA;
  typedef enum logic [2:0] {
    PSEL_FAULT_ONE, PSEL_FAULT_TWO, PSEL_FAULT_THREE, PSEL_ALARM_ONE, PSEL_ALARM_TWO
  } faw_psel_type;
  typedef struct packed {
    logic [15:0] fault_one;
    logic [15:0] fault_two;
    logic [15:0] fault_three;
    logic [15:0] alarm_one;
    logic [15:0] alarm_two;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    faw_psel_type panel_sel;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic [31:0] rdata;
  } faw_regs_type;
endpackage : faw_pkg

// file: faw_sync3.sv
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/100ps
module faw_sync3 #(
  parameter int WIDTH = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } faw_sync_type;
  faw_sync_type st_ff, nxt_st;
  logic [WIDTH-1:0] upd;
  if (WIDTH < 1) begin : g_chk
    $error("faw_sync3: WIDTH must be at least one");
  end
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    // stage one is read only by stage two
    assign upd[i] = (st_ff.s2[i] == st_ff.s3[i]) ? st_ff.s3[i] : st_ff.q[i];
  end
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.s1 = din;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      nxt_st.q = upd;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign dout = st_ff.q;
endmodule : faw_sync3

// file: faw_hex_panel.sv
// renders one status word as four ascii hex digits for the panel
`timescale 1ns/100ps
module faw_hex_panel (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic [15:0] word,
  output logic [31:0] digits
);
  typedef struct packed {
    logic [31:0] digits;
  } faw_hex_type;
  faw_hex_type st_ff, nxt_st;
  logic [31:0] asc;
  // digit 0 lands in the lowest byte: bit 0 alone gives 0001
  for (genvar i = 0; i < 4; i++) begin : g_digit
    assign asc[8*i +: 8] = (word[4*i +: 4] < faw_pkg::NIBBLE_TEN)
      ? faw_pkg::ASCII_ZERO + {4'h0, word[4*i +: 4]}
      : faw_pkg::ASCII_ALPHA + {4'h0, word[4*i +: 4]};
  end
  always_comb begin
    nxt_st = st_ff;
    if (ce) begin
      nxt_st.digits = asc;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign digits = st_ff.digits;
  hex_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && word == 16'h0001 |=> digits == 32'h30303031) else $error("bit 0 not shown as 0001");
  hex_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && word == 16'h8000 |=> digits == 32'h38303030) else $error("bit 15 not shown as 8000");
endmodule : faw_hex_panel

// file: faw_status_bank.sv
// fault and alarm status word bank with ahb-lite register access
// --------------------------------------------------------------
// Operation
// - active fault sets its fault word bit
// - each fault owns exactly one bit
// - fault words ignore bus writes
// - active alarm sets its alarm bit
// - each alarm owns its own bit
// - alarm bits latch until word cleared
// - writing zero clears the alarm word, except bits whose alarm is still active
// - words shown as four hex digits
// - word one bits zero to five mapped
// - word one bits 9,11,13,14,15 mapped
// - word two bits zero to five mapped
// - word two bits 11,13,14,15 mapped
// --------------------------------------------------------------
//
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module faw_status_bank #(
  parameter int WORD_W = faw_pkg::WORD_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic overcurrent,
  input wire logic bus_high_voltage_trip,
  input wire logic device_heat_trip,
  input wire logic output_short_trip,
  input wire logic overload,
  input wire logic bus_low_voltage_trip,
  input wire logic panel_loss,
  input wire logic motor_stall,
  input wire logic external_trip_one,
  input wire logic external_trip_two,
  input wire logic ground_leak_trip,
  input wire logic [15:0] fault_spare_one,
  input wire logic underload,
  input wire logic thermistor_failure,
  input wire logic option_link_lost,
  input wire logic option_power_lost,
  input wire logic current_sense_failure,
  input wire logic supply_phase_loss,
  input wire logic serial_link_error,
  input wire logic forced_shutdown,
  input wire logic motor_phase_loss,
  input wire logic output_cabling_fault,
  input wire logic [15:0] fault_spare_two,
  input wire logic [15:0] fault_cond_three,
  input wire logic [15:0] alarm_cond_one,
  input wire logic [15:0] alarm_cond_two,
  output logic irq,
  output logic [31:0] panel_hex
);
  if (WORD_W != 16) begin : g_chk
    $error("faw_status_bank: status words are 16 bits wide");
  end

  faw_pkg::faw_regs_type st_ff, nxt_st;
  logic [15:0] f1_raw, f2_raw;
  logic [79:0] raw_all, sync_all;
  logic [15:0] fq_one, fq_two, fq_three, aq_one, aq_two;
  logic [4:0] ev, stat_clr;
  logic acc;
  logic [15:0] panel_word;

  // --------------------------------------------------------------
  // fault word assembly
  // --------------------------------------------------------------
  // named faults override the spare lines, so no two share a bit
  always_comb begin
    f1_raw = fault_spare_one;
    f1_raw[faw_pkg::B1_OVERCURRENT] = overcurrent;
    f1_raw[faw_pkg::B1_BUS_HIGH] = bus_high_voltage_trip;
    f1_raw[faw_pkg::B1_HEAT] = device_heat_trip;
    f1_raw[faw_pkg::B1_SHORT] = output_short_trip;
    f1_raw[faw_pkg::B1_OVERLOAD] = overload;
    f1_raw[faw_pkg::B1_BUS_LOW] = bus_low_voltage_trip;
    f1_raw[faw_pkg::B1_PANEL_LOSS] = panel_loss;
    f1_raw[faw_pkg::B1_STALL] = motor_stall;
    f1_raw[faw_pkg::B1_EXT_ONE] = external_trip_one;
    f1_raw[faw_pkg::B1_EXT_TWO] = external_trip_two;
    f1_raw[faw_pkg::B1_GROUND] = ground_leak_trip;
    f2_raw = fault_spare_two;
    f2_raw[faw_pkg::B2_UNDERLOAD] = underload;
    f2_raw[faw_pkg::B2_THERMISTOR] = thermistor_failure;
    f2_raw[faw_pkg::B2_OPT_LINK] = option_link_lost;
    f2_raw[faw_pkg::B2_OPT_POWER] = option_power_lost;
    f2_raw[faw_pkg::B2_CURR_SENSE] = current_sense_failure;
    f2_raw[faw_pkg::B2_SUPPLY_PHASE] = supply_phase_loss;
    f2_raw[faw_pkg::B2_SERIAL_LINK] = serial_link_error;
    f2_raw[faw_pkg::B2_FORCED] = forced_shutdown;
    f2_raw[faw_pkg::B2_MOTOR_PHASE] = motor_phase_loss;
    f2_raw[faw_pkg::B2_CABLING] = output_cabling_fault;
  end

  // one bit per alarm line, taken straight from its own input
  assign raw_all = {alarm_cond_two, alarm_cond_one, fault_cond_three, f2_raw, f1_raw};

  faw_sync3 #(
    .WIDTH(80)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .din(raw_all),
    .dout(sync_all)
  );

  assign fq_one = sync_all[15:0];
  assign fq_two = sync_all[31:16];
  assign fq_three = sync_all[47:32];
  assign aq_one = sync_all[63:48];
  assign aq_two = sync_all[79:64];

  // --------------------------------------------------------------
  // read multiplexer
  // --------------------------------------------------------------
  function automatic logic [31:0] read_mux(input logic [31:0] addr, input faw_pkg::faw_regs_type s,
                                           input logic [31:0] hex);
    logic [31:0] d;
    d = '0;
    if (addr[31:8] == 24'h000000) begin
      unique case (addr[7:0])
        faw_pkg::OFS_FAULT_ONE: d = {16'h0000, s.fault_one};
        faw_pkg::OFS_FAULT_TWO: d = {16'h0000, s.fault_two};
        faw_pkg::OFS_FAULT_THREE: d = {16'h0000, s.fault_three};
        faw_pkg::OFS_ALARM_ONE: d = {16'h0000, s.alarm_one};
        faw_pkg::OFS_ALARM_TWO: d = {16'h0000, s.alarm_two};
        faw_pkg::OFS_IRQ_STAT: d = {27'h0000000, s.irq_stat};
        faw_pkg::OFS_IRQ_MASK: d = {27'h0000000, s.irq_mask};
        faw_pkg::OFS_PANEL_SEL: d = {29'h00000000, s.panel_sel};
        faw_pkg::OFS_PANEL_HEX: d = hex;
        default: d = '0;
      endcase
    end
    return d;
  endfunction : read_mux

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  // address phase taken only while the bank runs, so a frozen bank stalls the bus
  assign acc = hsel && htrans[1] && hready && ce;

  always_comb begin
    nxt_st = st_ff;
    stat_clr = '0;
    ev = '0;
    if (ce) begin
      // fault words are a plain mirror of the synchronised conditions
      nxt_st.fault_one = fq_one;
      nxt_st.fault_two = fq_two;
      nxt_st.fault_three = fq_three;
      nxt_st.alarm_one = st_ff.alarm_one | aq_one;
      nxt_st.alarm_two = st_ff.alarm_two | aq_two;
      ev[faw_pkg::IRQ_FAULT_ONE] = |(fq_one & ~st_ff.fault_one);
      ev[faw_pkg::IRQ_FAULT_TWO] = |(fq_two & ~st_ff.fault_two);
      ev[faw_pkg::IRQ_FAULT_THREE] = |(fq_three & ~st_ff.fault_three);
      ev[faw_pkg::IRQ_ALARM_ONE] = |(aq_one & ~st_ff.alarm_one);
      ev[faw_pkg::IRQ_ALARM_TWO] = |(aq_two & ~st_ff.alarm_two);
      if (st_ff.wr_pend) begin
        unique case (st_ff.wr_ofs)
          // a clear still keeps alarms active in the same cycle
          faw_pkg::OFS_ALARM_ONE: begin
            if (hwdata[15:0] == 16'h0000) begin
              nxt_st.alarm_one = aq_one;
            end
          end
          faw_pkg::OFS_ALARM_TWO: begin
            if (hwdata[15:0] == 16'h0000) begin
              nxt_st.alarm_two = aq_two;
            end
          end
          faw_pkg::OFS_IRQ_STAT: stat_clr = hwdata[4:0];
          faw_pkg::OFS_IRQ_MASK: nxt_st.irq_mask = hwdata[4:0];
          faw_pkg::OFS_PANEL_SEL: nxt_st.panel_sel = faw_pkg::faw_psel_type'(hwdata[2:0]);
          // fault words and unmapped offsets drop the write
          default: ;
        endcase
      end
      // set beats clear
      nxt_st.irq_stat = (st_ff.irq_stat & ~stat_clr) | ev;
      nxt_st.wr_pend = 1'b0;
      if (acc) begin
        nxt_st.wr_pend = hwrite && (haddr[31:8] == 24'h000000);
        nxt_st.wr_ofs = haddr[7:0];
        nxt_st.rdata = hwrite ? 32'h00000000 : read_mux(haddr, st_ff, panel_hex);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '{fault_one: faw_pkg::WORD_RST, fault_two: faw_pkg::WORD_RST,
                 fault_three: faw_pkg::WORD_RST, alarm_one: faw_pkg::WORD_RST,
                 alarm_two: faw_pkg::WORD_RST, irq_stat: faw_pkg::IRQ_RST,
                 irq_mask: faw_pkg::IRQ_RST, panel_sel: faw_pkg::PSEL_FAULT_ONE,
                 wr_pend: 1'b0, wr_ofs: 8'h00, rdata: 32'h00000000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // --------------------------------------------------------------
  // panel display
  // --------------------------------------------------------------
  always_comb begin
    unique case (st_ff.panel_sel)
      faw_pkg::PSEL_FAULT_TWO: panel_word = st_ff.fault_two;
      faw_pkg::PSEL_FAULT_THREE: panel_word = st_ff.fault_three;
      faw_pkg::PSEL_ALARM_ONE: panel_word = st_ff.alarm_one;
      faw_pkg::PSEL_ALARM_TWO: panel_word = st_ff.alarm_two;
      // codes 5 to 7 are writable but fall back to the first word
      default: panel_word = st_ff.fault_one;
    endcase
  end

  faw_hex_panel u_hex (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .word(panel_word),
    .digits(panel_hex)
  );

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  assign hreadyout = ce;
  assign hresp = 1'b0;
  assign hrdata = st_ff.rdata;
  assign irq = |(st_ff.irq_stat & st_ff.irq_mask);

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic wr_alarm_one, wr_fault;
  assign wr_alarm_one = ce && st_ff.wr_pend && st_ff.wr_ofs == faw_pkg::OFS_ALARM_ONE;
  assign wr_fault = ce && st_ff.wr_pend && st_ff.wr_ofs <= faw_pkg::OFS_FAULT_THREE;

  fault_mirror_a: assert property (ce |=> st_ff.fault_one == $past(fq_one)
                                   && st_ff.fault_two == $past(fq_two))
    else $error("fault word does not follow active faults");
  fault_readonly_a: assert property (wr_fault |=> st_ff.fault_three == $past(fq_three)
                                     && st_ff.fault_one == $past(fq_one))
    else $error("fault word altered by a write");
  fault_drop_a: assert property (ce && !fq_one[0] |=> !st_ff.fault_one[0])
    else $error("fault bit stayed after fault ended");
  alarm_set_a: assert property (ce |=> (st_ff.alarm_one & $past(aq_one)) == $past(aq_one))
    else $error("active alarm not latched");
  alarm_hold_a: assert property (ce && !wr_alarm_one
                                 |=> (st_ff.alarm_one & $past(st_ff.alarm_one))
                                     == $past(st_ff.alarm_one))
    else $error("alarm bit lost without a clear");
  alarm_clear_a: assert property (wr_alarm_one && hwdata[15:0] == 16'h0000
                                  |=> st_ff.alarm_one == $past(aq_one))
    else $error("zero write did not clear alarm word");
  alarm_keep_a: assert property (wr_alarm_one && hwdata[15:0] != 16'h0000
                                 |=> st_ff.alarm_one == ($past(st_ff.alarm_one) | $past(aq_one)))
    else $error("nonzero write changed alarm word");
  map_word_one_a: assert property ((ce && overcurrent && ground_leak_trip)[*6]
                                   |=> st_ff.fault_one[0] && st_ff.fault_one[15])
    else $error("word one mapping wrong");
  map_word_two_a: assert property ((ce && underload && serial_link_error)[*6]
                                   |=> st_ff.fault_two[0] && st_ff.fault_two[11])
    else $error("word two mapping wrong");
  map_unique_a: assert property ((ce && !overcurrent && fault_spare_one[0])[*6]
                                 |=> !st_ff.fault_one[0])
    else $error("spare line reached a named fault bit");
  irq_raise_a: assert property (ce && |(ev & st_ff.irq_mask)
                                |=> irq)
    else $error("unmasked event did not raise interrupt");

  alarm_clear_c: cover property (wr_alarm_one && hwdata[15:0] == 16'h0000 && st_ff.alarm_one != 0);
  alarm_keep_c: cover property (wr_alarm_one && hwdata[15:0] != 16'h0000);
  irq_c: cover property (!irq ##1 irq);
  fault_read_c: cover property (acc && !hwrite && haddr[7:0] == faw_pkg::OFS_FAULT_ONE);
endmodule : faw_status_bank

// file: faw_panel_model.sv
// operator panel model: turns the four ascii hex digits back into a word
`timescale 1ns/100ps
module faw_panel_model (
  input wire logic hclk,
  input wire logic [31:0] panel_hex,
  output logic [15:0] shown_word,
  output logic shown_ok
);
  // --------------------------------------------------------------
  // digit decode
  // --------------------------------------------------------------
  // a digit outside 0-9 and A-F marks the display as unreadable
  always_comb begin
    logic [7:0] ch;
    ch = 8'h00;
    shown_ok = 1'b1;
    shown_word = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      ch = panel_hex[8*i +: 8];
      if (ch >= 8'h30 && ch <= 8'h39) begin
        shown_word[4*i +: 4] = 4'(ch - 8'h30);
      end else if (ch >= 8'h41 && ch <= 8'h46) begin
        shown_word[4*i +: 4] = 4'(ch - 8'h37);
      end else begin
        shown_ok = 1'b0;
      end
    end
  end
endmodule : faw_panel_model

// file: tb.sv
// self-checking testbench for the fault and alarm status word bank
`timescale 1ns/100ps
module tb;
  logic hclk, hresetn, ce, hsel, hwrite, irq, hreadyout, hresp, shown_ok;
  logic [31:0] haddr, hwdata, hrdata, panel_hex, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] f1, f2, f3, a1, a2, shown_word;
  int err_total, checked;
  int pos1[11] = '{0, 1, 2, 3, 4, 5, 9, 11, 13, 14, 15};
  int pos2[10] = '{0, 1, 2, 3, 4, 5, 11, 13, 14, 15};

  // spare bit 0 runs opposite to overcurrent, so a leak past the named line shows
  faw_status_bank uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .overcurrent(f1[0]),
    .bus_high_voltage_trip(f1[1]), .device_heat_trip(f1[2]), .output_short_trip(f1[3]),
    .overload(f1[4]), .bus_low_voltage_trip(f1[5]), .panel_loss(f1[9]), .motor_stall(f1[11]),
    .external_trip_one(f1[13]), .external_trip_two(f1[14]), .ground_leak_trip(f1[15]),
    .fault_spare_one(f1 ^ 16'h0001), .underload(f2[0]), .thermistor_failure(f2[1]),
    .option_link_lost(f2[2]), .option_power_lost(f2[3]), .current_sense_failure(f2[4]),
    .supply_phase_loss(f2[5]), .serial_link_error(f2[11]), .forced_shutdown(f2[13]),
    .motor_phase_loss(f2[14]), .output_cabling_fault(f2[15]), .fault_spare_two(f2),
    .fault_cond_three(f3), .alarm_cond_one(a1), .alarm_cond_two(a2), .irq(irq),
    .panel_hex(panel_hex));

  faw_panel_model panel (.hclk(hclk), .panel_hex(panel_hex), .shown_word(shown_word),
    .shown_ok(shown_ok));

  // --------------------------------------------------------------
  // clock, compare and bus tasks
  // --------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk32

  task automatic chk1(input logic got, input logic exp, input string what);
    chk32({31'h0, got}, {31'h0, exp}, what);
  endtask : chk1

  // no wait count is assumed: the slave's hready ends each phase
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) chk1(1'b0, 1'b1, "hready never came");
  endtask : wait_rdy

  task automatic xfer(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, ofs};
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk1(hresp, 1'b0, "response not okay");
  endtask : xfer

  task automatic rchk(input logic [7:0] ofs, input logic [31:0] exp, input string what);
    xfer(1'b0, ofs, 32'h00000000);
    chk32(rd, exp, what);
  endtask : rchk

  task automatic settle;
    repeat (8) @(posedge hclk);
  endtask : settle

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  // --------------------------------------------------------------
  // test sequence
  // --------------------------------------------------------------
  initial begin
    hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h00000000; htrans = 2'b00;
    hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h00000000;
    f1 = 16'h0000; f2 = 16'h0000; f3 = 16'h0000; a1 = 16'h0000; a2 = 16'h0000;
    err_total = 0; checked = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) rchk(8'(4 * i), 32'h00000000, "reset value");
    rchk(faw_pkg::OFS_PANEL_HEX, 32'h30303030, "panel copy after reset");
    chk1(irq, 1'b0, "irq after reset");
    // one named fault at a time must light only its own bit
    foreach (pos1[i]) begin
      f1 <= 16'(1 << pos1[i]);
      settle();
      rchk(faw_pkg::OFS_FAULT_ONE, 32'(1 << pos1[i]), "fault word one bit");
      chk32({16'h0000, shown_word}, 32'(1 << pos1[i]), "panel word");
      if (pos1[i] == 0) chk32(panel_hex, 32'h30303031, "panel digits bit 0");
      if (pos1[i] == 15) chk32(panel_hex, 32'h38303030, "panel digits bit 15");
    end
    foreach (pos2[i]) begin
      f2 <= 16'(1 << pos2[i]);
      settle();
      rchk(faw_pkg::OFS_FAULT_TWO, 32'(1 << pos2[i]), "fault word two bit");
    end
    f1 <= 16'hFFFF;
    f2 <= 16'hFFFF;
    f3 <= 16'hA5C3;
    settle();
    rchk(faw_pkg::OFS_FAULT_ONE, 32'h0000FFFF, "all faults word one");
    rchk(faw_pkg::OFS_FAULT_TWO, 32'h0000FFFF, "all faults word two");
    rchk(faw_pkg::OFS_FAULT_THREE, 32'h0000A5C3, "fault word three");
    for (int i = 0; i < 3; i++) xfer(1'b1, 8'(4 * i), 32'h00000000);
    rchk(faw_pkg::OFS_FAULT_ONE, 32'h0000FFFF, "write to fault word one");
    rchk(faw_pkg::OFS_FAULT_THREE, 32'h0000A5C3, "write to fault word three");
    f1 <= 16'h0000;
    f2 <= 16'h0000;
    f3 <= 16'h0000;
    settle();
    rchk(faw_pkg::OFS_FAULT_ONE, 32'h00000000, "fault drops away");
    rchk(faw_pkg::OFS_FAULT_TWO, 32'h00000000, "fault two drops away");
    // alarms latch past their cause; only a zero write clears them
    a1 <= 16'h0009;
    a2 <= 16'h8080;
    settle();
    a1 <= 16'h0000;
    a2 <= 16'h0000;
    settle();
    rchk(faw_pkg::OFS_ALARM_ONE, 32'h00000009, "alarm one latched");
    rchk(faw_pkg::OFS_ALARM_TWO, 32'h00008080, "alarm two latched");
    xfer(1'b1, faw_pkg::OFS_ALARM_ONE, 32'h00000009);
    rchk(faw_pkg::OFS_ALARM_ONE, 32'h00000009, "nonzero write kept");
    xfer(1'b1, faw_pkg::OFS_ALARM_ONE, 32'h00000000);
    rchk(faw_pkg::OFS_ALARM_ONE, 32'h00000000, "alarm one cleared");
    rchk(faw_pkg::OFS_ALARM_TWO, 32'h00008080, "alarm two untouched");
    xfer(1'b1, faw_pkg::OFS_ALARM_TWO, 32'h00000000);
    rchk(faw_pkg::OFS_ALARM_TWO, 32'h00000000, "alarm two cleared");
    // a frozen bank must not take an alarm pulse that ends before it runs again
    ce <= 1'b0;
    a2 <= 16'h0100;
    settle();
    a2 <= 16'h0000;
    ce <= 1'b1;
    settle();
    rchk(faw_pkg::OFS_ALARM_TWO, 32'h00000000, "frozen bank latched alarm");
    // interrupt: raised into status, masked, unmasked, cleared by one
    xfer(1'b1, faw_pkg::OFS_IRQ_STAT, 32'h0000001F);
    rchk(faw_pkg::OFS_IRQ_STAT, 32'h00000000, "status cleared");
    f3 <= 16'h0001;
    settle();
    rchk(faw_pkg::OFS_IRQ_STAT, 32'h00000004, "fault three event");
    chk1(irq, 1'b0, "irq masked");
    xfer(1'b1, faw_pkg::OFS_IRQ_MASK, 32'h00000004);
    repeat (2) @(posedge hclk);
    chk1(irq, 1'b1, "irq unmasked");
    xfer(1'b1, faw_pkg::OFS_IRQ_STAT, 32'h00000004);
    repeat (2) @(posedge hclk);
    chk1(irq, 1'b0, "irq cleared");
    f3 <= 16'h0000;
    settle();
    f3 <= 16'h0001;
    settle();
    chk1(irq, 1'b1, "irq on masked-in event");
    // panel shows the selected word; unmapped places read zero
    xfer(1'b1, faw_pkg::OFS_PANEL_SEL, 32'h00000002);
    settle();
    chk32({16'h0000, shown_word}, 32'h00000001, "panel word three");
    chk1(shown_ok, 1'b1, "panel digits readable");
    xfer(1'b1, 8'h40, 32'hFFFFFFFF);
    rchk(8'h40, 32'h00000000, "unmapped read");
    report_and_stop();
  end

  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule : tb
